// >>> design/prs_pkg.sv
// Constants, carriers and state type for the reset and power-down sequencer
package prs_pkg;
    // Clock and delay figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int POR_DELAY_MS = 128;
    localparam int XTAL_DELAY_MS = 150;
    localparam int LOCK_DELAY_MS = 1;
    // Least times round up to whole cycles
    localparam int POR_CYCLES = (POR_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XTAL_CYCLES = (XTAL_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CYCLES = (LOCK_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam int CD_W = 3;
    localparam int WS_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [CD_W-1:0] CD_RESET = 3'h3;
    // One-hot wake source codes
    localparam logic [WS_W-1:0] WS_NONE = 3'h0;
    localparam logic [WS_W-1:0] WS_TIC = 3'h1;
    localparam logic [WS_W-1:0] WS_SPI = 3'h2;
    localparam logic [WS_W-1:0] WS_INT0 = 3'h4;

    // Wake bits of the power control register
    typedef struct packed {
        logic spi_wake_enable;
        logic ext_int0_wake_enable;
    } prs_pwr_ctl_t;

    // Fields of the PLL control register that software writes
    typedef struct packed {
        logic oscillator_power_down;
        logic [CD_W-1:0] core_clock_divider;
    } prs_pll_ctl_t;

    // Wake interrupt requests and their enables
    typedef struct packed {
        logic tic_irq;
        logic tic_en;
        logic spi_irq;
        logic spi_irq_en;
        logic int0_irq;
        logic int0_en;
    } prs_wake_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_PINRST,
        ST_RUN,
        ST_PD,
        ST_XTAL,
        ST_LOCK
    } prs_st_t;

    // Whole state of the sequencer
    typedef struct packed {
        prs_st_t st;
        logic [CNT_W-1:0] cnt;
        logic osc_off;
        logic lock;
        logic wake;
        logic [WS_W-1:0] wake_src;
        logic [CD_W-1:0] clk_div;
    } prs_state_t;
endpackage : prs_pkg

// >>> design/prs_top.sv
// Power-on reset, power-down entry, hold and wake-up sequencer
//
// What this block does
// R1: Hold reset below threshold, then 128 ms delay
// R2: Falling supply keeps reset until fully dead
// R3: Power-down bit write enters full power-down; ignored during crystal start
// R4: Power-down stops PLL and core clock
// R5: Oscillator runs in power-down unless powered down
// R6: Only interval timer runs; other peripherals off
// R7: Ports hold, DAC tri-states, strobes driven low
// R8: Reset pin restores defaults, resumes at vector
// R9: Power cycle restarts after 128 ms delay
// R10: Enabled interval timer with oscillator wakes device
// R11: Wake resumes after power-down instruction, no reset
// R12: Enabled SPI interrupt with wake bit wakes
// R13: Enabled external interrupt 0 with wake bit wakes
// R14: Core executes unlocked for about 1 ms
// R15: Lock flag reported; software polls it
// R16: Halted oscillator adds 150 ms start-up delay
// R17: Software lowers core clock through divider field
// R18: Disabled wake sources ignored; stay powered down
`timescale 1ns/1ns
module prs_top
    import prs_pkg::*;
#(
    parameter int POR_CYC_P = POR_CYCLES,
    parameter int XTAL_CYC_P = XTAL_CYCLES,
    parameter int LOCK_CYC_P = LOCK_CYCLES
) (
    input wire logic CLK_I,                 // System clock, 100 MHz
    input wire logic RESETN_I,              // Async reset, active low
    input wire logic SUPPLY_OK_I,           // Digital supply above reset threshold
    input wire logic RESET_PIN_I,           // External reset pin, high asserted
    input wire logic PD_SET_I,              // Pulse: power-down bit written 1
    input wire prs_pwr_ctl_t PWR_CTL_I,     // Wake enable bits
    input wire prs_pll_ctl_t PLL_CTL_I,     // Oscillator and divider fields
    input wire prs_wake_t WAKE_I,           // Wake requests and enables
    input wire logic ALE_I,                 // Core address latch strobe
    input wire logic PSTROBE_I,             // Core program store strobe
    output logic CORE_RESET_O,              // Core and registers held in reset
    output logic PD_ACTIVE_O,               // Power-down in force
    output logic PLL_EN_O,                  // PLL running
    output logic CORE_CLK_EN_O,             // Core clock running
    output logic OSC_EN_O,                  // 32 kHz oscillator running
    output logic TIC_RUN_O,                 // Interval timer running
    output logic PERIPH_EN_O,               // Other peripherals powered
    output logic PORT_HOLD_O,               // Port pins latched
    output logic DAC_OE_O,                  // DAC driven; low is high impedance
    output logic ALE_O,                     // Address latch strobe pin
    output logic PSTROBE_O,                 // Program store strobe pin
    output logic WAKE_O,                    // Pulse: wake interrupt to core
    output logic [WS_W-1:0] WAKE_SRC_O,     // Source of last wake, one-hot
    output logic LOCK_O,                    // PLL lock status bit
    output logic [CD_W-1:0] CLK_DIV_O       // Core clock divider to clock tree
);

    // Parameters must fit the shared counter
    if (POR_CYC_P < 1 || POR_CYC_P > (1 << CNT_W)) begin : g_chk_por
        $error("POR_CYC_P out of range");
    end
    if (XTAL_CYC_P < 1 || XTAL_CYC_P > (1 << CNT_W)) begin : g_chk_xtal
        $error("XTAL_CYC_P out of range");
    end
    if (LOCK_CYC_P < 1 || LOCK_CYC_P > (1 << CNT_W)) begin : g_chk_lock
        $error("LOCK_CYC_P out of range");
    end

    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC_P - 1);
    localparam logic [CNT_W-1:0] XTAL_LAST = CNT_W'(XTAL_CYC_P - 1);
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC_P - 1);

    prs_state_t q;
    prs_state_t d;
    logic wake_tic;
    logic wake_spi;
    logic wake_int0;

    // Qualified wake requests; anything else is ignored
    assign wake_tic = WAKE_I.tic_irq && WAKE_I.tic_en && !q.osc_off; // see R10 see R18
    assign wake_spi = WAKE_I.spi_irq && WAKE_I.spi_irq_en && PWR_CTL_I.spi_wake_enable; // see R12
    assign wake_int0 = WAKE_I.int0_irq && WAKE_I.int0_en && PWR_CTL_I.ext_int0_wake_enable; // see R13

    // Next-state logic
    always_comb begin
        d = q;
        d.wake = 1'b0;
        d.clk_div = PLL_CTL_I.core_clock_divider; // see R17
        case (q.st)
            ST_POR: begin
                if (q.cnt == POR_LAST) begin // see R1 see R9
                    d.st = ST_RUN;
                    d.cnt = CNT_ZERO;
                    d.lock = 1'b1;
                end else begin
                    d.cnt = q.cnt + CNT_ONE;
                end
            end
            ST_PINRST: begin
                if (!RESET_PIN_I) begin // see R8
                    d.st = q.osc_off ? ST_XTAL : ST_LOCK;
                    d.cnt = CNT_ZERO;
                end
            end
            ST_RUN, ST_LOCK: begin
                if (PD_SET_I) begin // see R3
                    d.st = ST_PD;
                    d.cnt = CNT_ZERO;
                    d.lock = 1'b0;
                    d.osc_off = PLL_CTL_I.oscillator_power_down; // see R5
                end else if (q.st == ST_LOCK) begin
                    if (q.cnt == LOCK_LAST) begin // see R14
                        d.st = ST_RUN;
                        d.cnt = CNT_ZERO;
                        d.lock = 1'b1; // see R15
                    end else begin
                        d.cnt = q.cnt + CNT_ONE;
                    end
                end
            end
            ST_PD: begin
                // Priority: timer, then SPI, then external interrupt 0
                if (wake_tic || wake_spi || wake_int0) begin // see R11 see R18
                    d.wake = 1'b1;
                    d.wake_src = wake_tic ? WS_TIC : (wake_spi ? WS_SPI : WS_INT0);
                    d.st = q.osc_off ? ST_XTAL : ST_LOCK;
                    d.cnt = CNT_ZERO;
                end
            end
            ST_XTAL: begin
                if (q.cnt == XTAL_LAST) begin // see R16
                    d.st = ST_LOCK;
                    d.cnt = CNT_ZERO;
                    d.osc_off = 1'b0;
                end else begin
                    d.cnt = q.cnt + CNT_ONE;
                end
            end
            default: begin
                d.st = ST_POR;
                d.cnt = CNT_ZERO;
            end
        endcase
        // Reset pin overrides every running state
        if (RESET_PIN_I && q.st != ST_POR) begin // see R8
            d.st = ST_PINRST;
            d.cnt = CNT_ZERO;
            d.lock = 1'b0;
            d.wake = 1'b0;
            d.wake_src = WS_NONE;
            d.clk_div = CD_RESET;
        end
        // Low supply restarts the power-on delay and holds it
        if (!SUPPLY_OK_I) begin // see R1 see R2 see R9
            d.st = ST_POR;
            d.cnt = CNT_ZERO;
            d.osc_off = 1'b0;
            d.lock = 1'b0;
            d.wake = 1'b0;
            d.wake_src = WS_NONE;
            d.clk_div = CD_RESET;
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q <= '{st: ST_POR, cnt: CNT_ZERO, osc_off: 1'b0, lock: 1'b0,
                   wake: 1'b0, wake_src: WS_NONE, clk_div: CD_RESET};
        end else begin
            q <= d;
        end
    end

    // Output decode from registered state
    assign CORE_RESET_O = (q.st == ST_POR) || (q.st == ST_PINRST); // see R8 see R9
    assign PD_ACTIVE_O = (q.st == ST_PD);
    assign PLL_EN_O = (q.st == ST_RUN) || (q.st == ST_LOCK) || (q.st == ST_POR)
                      || (q.st == ST_PINRST && !q.osc_off); // see R4 see R16
    assign CORE_CLK_EN_O = (q.st != ST_PD); // see R4 see R14
    assign OSC_EN_O = !(q.st == ST_PD && q.osc_off); // see R5
    assign TIC_RUN_O = WAKE_I.tic_en && OSC_EN_O; // see R6
    assign PERIPH_EN_O = (q.st != ST_PD); // see R6
    assign PORT_HOLD_O = (q.st == ST_PD); // see R7
    assign DAC_OE_O = (q.st != ST_PD); // see R7
    assign ALE_O = ALE_I && (q.st != ST_PD); // see R7
    assign PSTROBE_O = PSTROBE_I && (q.st != ST_PD); // see R7
    assign WAKE_O = q.wake;
    assign WAKE_SRC_O = q.wake_src;
    assign LOCK_O = q.lock; // see R15
    assign CLK_DIV_O = q.clk_div;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    // Named steps of a wake: quiet power-down, then the pulse
    sequence s_pd_quiet;
        PD_ACTIVE_O && SUPPLY_OK_I && !RESET_PIN_I;
    endsequence
    sequence s_wake_pulse;
        WAKE_O && !PD_ACTIVE_O && !CORE_RESET_O;
    endsequence
    // Any qualified wake while powered down and undisturbed
    sequence s_wake_req;
        s_pd_quiet ##0 (wake_tic || wake_spi || wake_int0);
    endsequence

    a_supply_hold: assert property (!SUPPLY_OK_I |=> CORE_RESET_O && !LOCK_O) // see R1
        else $error("reset not held on low supply");
    a_por_release: assert property ($fell(CORE_RESET_O) && $past(q.st) == ST_POR
        |-> $past(q.cnt) == POR_LAST) // see R9
        else $error("power-on delay wrong length");
    a_pd_entry: assert property ((q.st == ST_RUN) && PD_SET_I && SUPPLY_OK_I && !RESET_PIN_I
        |=> PD_ACTIVE_O) // see R3
        else $error("power-down not entered");
    a_pd_clocks: assert property (PD_ACTIVE_O |-> !PLL_EN_O && !CORE_CLK_EN_O && !PERIPH_EN_O) // see R4
        else $error("clocks running in power-down");
    a_osc_keep: assert property ((q.st == ST_RUN) && PD_SET_I && SUPPLY_OK_I && !RESET_PIN_I
        |=> OSC_EN_O == !$past(PLL_CTL_I.oscillator_power_down)) // see R5
        else $error("oscillator state wrong in power-down");
    a_tic_run: assert property (PD_ACTIVE_O |-> TIC_RUN_O == (WAKE_I.tic_en && !q.osc_off)) // see R6
        else $error("interval timer state wrong");
    a_pd_pins: assert property (PD_ACTIVE_O |-> PORT_HOLD_O && !DAC_OE_O && !ALE_O && !PSTROBE_O) // see R7
        else $error("pin state wrong in power-down");
    a_pin_reset: assert property (PD_ACTIVE_O && RESET_PIN_I && SUPPLY_OK_I
        |=> CORE_RESET_O [*1] ##1 (CORE_RESET_O || !$past(RESET_PIN_I))) // see R8
        else $error("reset pin not honoured");
    a_tic_wake: assert property (s_pd_quiet ##0 wake_tic |=> s_wake_pulse ##0 WAKE_SRC_O == WS_TIC) // see R10
        else $error("interval timer wake missed");
    a_spi_wake: assert property (s_pd_quiet ##0 (wake_spi && !wake_tic)
        |=> s_wake_pulse ##0 WAKE_SRC_O == WS_SPI) // see R12
        else $error("SPI wake missed");
    a_int0_wake: assert property (s_pd_quiet ##0 (wake_int0 && !wake_tic && !wake_spi)
        |=> s_wake_pulse ##0 WAKE_SRC_O == WS_INT0) // see R13
        else $error("external interrupt 0 wake missed");
    a_no_wake: assert property (s_pd_quiet ##0 !(wake_tic || wake_spi || wake_int0)
        |=> PD_ACTIVE_O && !WAKE_O) // see R18
        else $error("left power-down without wake");
    a_wake_noreset: assert property (WAKE_O |-> !CORE_RESET_O ##1 (!CORE_RESET_O || !$past(SUPPLY_OK_I)
        || $past(RESET_PIN_I))) // see R11
        else $error("wake reset the core");
    a_lock_wait: assert property (q.st == ST_LOCK |-> !LOCK_O && CORE_CLK_EN_O && PLL_EN_O) // see R14
        else $error("lock wait state wrong");
    a_lock_flag: assert property ($rose(LOCK_O) |-> $past(q.cnt) == LOCK_LAST
        || $past(q.cnt) == POR_LAST) // see R15
        else $error("lock flag set early");
    a_xtal_wait: assert property (q.st == ST_XTAL |-> !PLL_EN_O && !LOCK_O && OSC_EN_O) // see R16
        else $error("PLL started before crystal");
    a_clk_div: assert property (SUPPLY_OK_I && !RESET_PIN_I
        |=> CLK_DIV_O == $past(PLL_CTL_I.core_clock_divider)) // see R17
        else $error("divider not applied");

    // Power-on state keeps everything in reset
    a_por_hold: assert property (q.st == ST_POR |-> CORE_RESET_O && !LOCK_O && !PD_ACTIVE_O) // see R1
        else $error("power-on state not in reset");
    // Power-on count advances one step per clock
    a_por_count: assert property ((q.st == ST_POR) && SUPPLY_OK_I && (q.cnt != POR_LAST) // see R1
        |=> (q.st == ST_POR) && (q.cnt == $past(q.cnt) + CNT_ONE))
        else $error("power-on count not advancing");
    // Low supply clears the count and wake record
    a_supply_restart: assert property (!SUPPLY_OK_I // see R2
        |=> (q.cnt == CNT_ZERO) && !WAKE_O && (WAKE_SRC_O == WS_NONE))
        else $error("low supply did not restart");
    // Power-down may also be entered while waiting for lock
    a_lock_pd_entry: assert property ((q.st == ST_LOCK) && PD_SET_I && SUPPLY_OK_I && !RESET_PIN_I // see R3
        |=> PD_ACTIVE_O && !LOCK_O)
        else $error("power-down refused during lock wait");
    // Power-down request ignored during crystal start
    a_xtal_pd_refuse: assert property ((q.st == ST_XTAL) && PD_SET_I && SUPPLY_OK_I && !RESET_PIN_I // see R3
        && (q.cnt != XTAL_LAST)
        |=> q.st == ST_XTAL)
        else $error("power-down taken during crystal start");
    // Oscillator always runs outside power-down
    a_osc_run: assert property (!PD_ACTIVE_O |-> OSC_EN_O) // see R5
        else $error("oscillator stopped outside power-down");
    // Halted oscillator also stops the interval timer
    a_osc_stop: assert property (PD_ACTIVE_O && q.osc_off |-> !OSC_EN_O && !TIC_RUN_O) // see R5
        else $error("oscillator running while halted");
    // Peripherals and DAC powered outside power-down
    a_periph_run: assert property (!PD_ACTIVE_O |-> PERIPH_EN_O && DAC_OE_O && !PORT_HOLD_O) // see R6
        else $error("peripherals off outside power-down");
    // Strobes pass straight through outside power-down
    a_strobe_pass: assert property (!PD_ACTIVE_O // see R7
        |-> (ALE_O == ALE_I) && (PSTROBE_O == PSTROBE_I))
        else $error("strobe not passed through");
    // Held reset pin keeps the core reset and clears the record
    a_pinrst_hold: assert property ((q.st == ST_PINRST) && RESET_PIN_I && SUPPLY_OK_I // see R8
        |=> CORE_RESET_O && !LOCK_O && (WAKE_SRC_O == WS_NONE) && (CLK_DIV_O == CD_RESET))
        else $error("reset pin hold broken");
    // Pin release lets the core run at once
    a_pin_release: assert property ((q.st == ST_PINRST) && !RESET_PIN_I && SUPPLY_OK_I // see R8
        |=> !CORE_RESET_O && !PD_ACTIVE_O && !LOCK_O)
        else $error("core not released after reset pin");
    // Reset pin also resets a running core
    a_run_pin: assert property ((q.st == ST_RUN) && RESET_PIN_I && SUPPLY_OK_I // see R8
        |=> CORE_RESET_O && (CLK_DIV_O == CD_RESET))
        else $error("reset pin ignored while running");
    // Wake pulse lasts exactly one cycle
    a_wake_seq: assert property (s_wake_req |=> s_wake_pulse ##1 !WAKE_O) // see R11
        else $error("wake pulse length wrong");
    // Running oscillator goes straight to lock wait
    a_wake_lock: assert property (s_wake_req ##0 !q.osc_off // see R14
        |=> (q.st == ST_LOCK) && PLL_EN_O && CORE_CLK_EN_O && !LOCK_O)
        else $error("wake did not start lock wait");
    // Halted oscillator first waits for the crystal
    a_wake_xtal: assert property (s_wake_req ##0 q.osc_off // see R16
        |=> (q.st == ST_XTAL) && !PLL_EN_O && CORE_CLK_EN_O && OSC_EN_O)
        else $error("wake skipped crystal start");
    // Crystal wait ends in lock wait with PLL on
    a_xtal_done: assert property ((q.st == ST_XTAL) && (q.cnt == XTAL_LAST) && SUPPLY_OK_I // see R16
        && !RESET_PIN_I
        |=> (q.st == ST_LOCK) && PLL_EN_O && OSC_EN_O && !LOCK_O)
        else $error("crystal wait did not end");
    // Lock wait ends with the lock bit set
    a_lock_done: assert property ((q.st == ST_LOCK) && (q.cnt == LOCK_LAST) && SUPPLY_OK_I // see R15
        && !RESET_PIN_I && !PD_SET_I
        |=> LOCK_O && (q.st == ST_RUN))
        else $error("lock bit not set after wait");
    // Lock bit stays set while undisturbed
    a_lock_stay: assert property (LOCK_O && !PD_SET_I && SUPPLY_OK_I && !RESET_PIN_I |=> LOCK_O) // see R15
        else $error("lock bit dropped");
    // Wake record changes only on a wake or a reset
    a_src_hold: assert property (SUPPLY_OK_I && !RESET_PIN_I && !(PD_ACTIVE_O && // see R18
        (wake_tic || wake_spi || wake_int0))
        |=> $stable(WAKE_SRC_O))
        else $error("wake source changed without wake");
    // Divider falls back to its default on low supply or on the reset pin outside ST_POR
    a_div_reset: assert property (!SUPPLY_OK_I || (RESET_PIN_I && (q.st != ST_POR)) // see R17
        |=> CLK_DIV_O == CD_RESET)
        else $error("divider not reset");

endmodule : prs_top

// >>> bench/prs_core_model.sv
// Core and wake source model facing the sequencer
`timescale 1ns/1ns
module prs_core_model
    import prs_pkg::*;
(
    input wire logic clk_i,        // System clock
    input wire logic wake_i,       // Wake pulse from sequencer
    input wire logic core_reset_i, // Core held in reset
    input wire logic lock_i,       // PLL lock status bit
    output logic pd_set_o,         // Power-down bit write pulse
    output prs_wake_t wake_o,      // Wake requests and enables
    output logic ale_o,            // Address latch strobe
    output logic pstrobe_o         // Program store strobe
);
    initial begin
        pd_set_o = 1'b0;
        wake_o = '0;
        ale_o = 1'b0;
        pstrobe_o = 1'b0;
    end
    // Strobes run with the core; ISR clears requests on wake
    always @(posedge clk_i) begin
        #1;
        ale_o = !core_reset_i && !ale_o;
        pstrobe_o = !core_reset_i;
        if (wake_i) begin
            wake_o.tic_irq = 1'b0;
            wake_o.spi_irq = 1'b0;
            wake_o.int0_irq = 1'b0;
        end
    end
    // Wake request and enable levels set by the sources
    task automatic set_wake(input prs_wake_t v);
        wake_o = v;
    endtask : set_wake
    // Software write of one to the power-down bit
    task automatic pd_pulse();
        pd_set_o = 1'b1;
        @(posedge clk_i);
        #1;
        pd_set_o = 1'b0;
    endtask : pd_pulse
    // Software polls the lock bit before timed work
    task automatic wait_lock(output int n);
        n = 0;
        while (lock_i !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : wait_lock
endmodule : prs_core_model

// >>> bench/prs_top_bench.sv
// Self-checking bench for the reset and power-down sequencer
`timescale 1ns/1ns
module prs_top_bench;
    import prs_pkg::*;
    localparam int POR_C = 20;
    localparam int XTAL_C = 30;
    localparam int LOCK_C = 10;
    logic clk, rstn, supply, pin, pd_set, ale_i, pstr_i;
    logic core_rst, pd_act, pll_en, cclk_en, osc_en, tic_run, per_en, hold, dac_oe, ale, pstr, wake, lock;
    logic [WS_W-1:0] src;
    logic [CD_W-1:0] div;
    prs_pwr_ctl_t pwr;
    prs_pll_ctl_t pll;
    prs_wake_t wk;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    prs_top #(.POR_CYC_P(POR_C), .XTAL_CYC_P(XTAL_C), .LOCK_CYC_P(LOCK_C)) dut (
        .CLK_I(clk), .RESETN_I(rstn), .SUPPLY_OK_I(supply), .RESET_PIN_I(pin),
        .PD_SET_I(pd_set), .PWR_CTL_I(pwr), .PLL_CTL_I(pll), .WAKE_I(wk),
        .ALE_I(ale_i), .PSTROBE_I(pstr_i), .CORE_RESET_O(core_rst), .PD_ACTIVE_O(pd_act),
        .PLL_EN_O(pll_en), .CORE_CLK_EN_O(cclk_en), .OSC_EN_O(osc_en), .TIC_RUN_O(tic_run),
        .PERIPH_EN_O(per_en), .PORT_HOLD_O(hold), .DAC_OE_O(dac_oe), .ALE_O(ale),
        .PSTROBE_O(pstr), .WAKE_O(wake), .WAKE_SRC_O(src), .LOCK_O(lock), .CLK_DIV_O(div)
    );
    prs_core_model core (
        .clk_i(clk), .wake_i(wake), .core_reset_i(core_rst), .lock_i(lock),
        .pd_set_o(pd_set), .wake_o(wk), .ale_o(ale_i), .pstrobe_o(pstr_i)
    );
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt
    // Edges until the core leaves reset
    task automatic run_count(output int c);
        tick();
        c = 1;
        while (core_rst !== 1'b0 && c < 100) begin
            tick();
            c++;
        end
    endtask : run_count
    task automatic pd_enter(input logic osc);
        pll.oscillator_power_down = osc;
        core.pd_pulse();
        chk({pd_act, pll_en, cclk_en, per_en, dac_oe, hold, ale, pstr, osc_en, tic_run},
            {6'b100001, 2'b00, !osc, wk.tic_en && !osc});
    endtask : pd_enter
    // Wake by source k with the unqualified cases refused first
    task automatic t_wake(input int k);
        logic [2:0] e;
        e = 3'h1 << k;
        pd_enter(1'b0);
        pwr = 2'h3;
        core.set_wake(wk | (6'h20 >> (2 * k)));
        repeat (3) tick();
        chk(pd_act, 1'b1);
        if (k > 0) begin
            pwr = 2'h0;
            core.set_wake(wk | (6'h10 >> (2 * k)));
            repeat (3) tick();
            chk(pd_act, 1'b1);
        end
        pwr = 2'h3;
        core.set_wake(wk | (6'h10 >> (2 * k)));
        tick();
        chk({wake, src, core_rst, pd_act, lock}, {1'b1, e, 3'b000});
        core.wait_lock(n);
        chk_cnt(n, LOCK_C);
        core.set_wake('0);
    endtask : t_wake
    task automatic t_xtal();
        pd_enter(1'b1);
        core.set_wake(6'h30);
        repeat (3) tick();
        chk(pd_act, 1'b1);
        core.set_wake(6'h03);
        tick();
        chk({wake, src, pll_en, cclk_en}, {1'b1, WS_INT0, 2'b01});
        core.wait_lock(n);
        chk_cnt(n, XTAL_C + LOCK_C);
        core.set_wake('0);
    endtask : t_xtal
    task automatic t_pin();
        pll.core_clock_divider = 3'h5;
        repeat (2) tick();
        chk(div, 3'h5);
        pd_enter(1'b0);
        pin = 1'b1;
        tick();
        chk({core_rst, src, div}, {1'b1, WS_NONE, CD_RESET});
        pin = 1'b0;
        tick();
        chk(core_rst, 1'b0);
        core.wait_lock(n);
        chk_cnt(n, LOCK_C);
        chk({pstr, dac_oe, per_en, hold, osc_en}, 5'b11101);
    endtask : t_pin
    task automatic t_supply();
        supply = 1'b0;
        tick();
        chk(core_rst, 1'b1);
        repeat (5) tick();
        supply = 1'b1;
        run_count(n);
        chk_cnt(n, POR_C);
    endtask : t_supply
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        rstn = 1'b0;
        supply = 1'b1;
        pin = 1'b0;
        pwr = 2'h0;
        pll = 4'h3;
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        run_count(n);
        chk_cnt(n, POR_C);
        chk(lock, 1'b1);
        for (int k = 0; k < 3; k++) begin
            t_wake(k);
        end
        t_xtal();
        t_pin();
        t_supply();
        final_report();
    end
endmodule : prs_top_bench
